/* core/pv_cond_defines.svh */
// offsets, field positions, reset values and timing counts of the pv conditioning block
`ifndef PV_COND_DEFINES_SVH
`define PV_COND_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets (wishbone, one 32-bit word each)
// ----------------------------------------------------------------------
`define REG_CTRL      8'h00
`define REG_BIAS1     8'h04
`define REG_BIAS2     8'h08
`define REG_SLOPE1    8'h0c
`define REG_SLOPE2    8'h10
`define REG_FILT1     8'h14
`define REG_FILT2     8'h18
`define REG_SCALE_LO  8'h1c
`define REG_SCALE_HI  8'h20
`define REG_SV_FILT   8'h24
`define REG_STATUS    8'h28
`define REG_PV        8'h2c
`define REG_SLAVE_SV  8'h30
`define REG_COND1     8'h34
`define REG_COND2     8'h38

// ----------------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------------
`define CTRL_SEL_LO   0
`define CTRL_SEL_HI   2
`define CTRL_POLICY   3
`define CTRL_HOLD     4
`define CTRL_CASCADE  5
`define CTRL_LINEAR1  6
`define CTRL_LINEAR2  7

// status word fields
`define STAT_SEL_REJ   0
`define STAT_SCALE_REJ 1
`define STAT_RANGE_REJ 2
`define STAT_OVER      3
`define STAT_OVER1     4
`define STAT_OVER2     5

// ----------------------------------------------------------------------
// value limits and reset values
// ----------------------------------------------------------------------
`define PV_W          20
`define BIAS_MIN      (-16'sd10000)
`define BIAS_MAX      16'sd10000
`define SLOPE_MIN     11'd500
`define SLOPE_MAX     11'd1500
`define SLOPE_UNITY   11'd1000
`define SLOPE_SCALE   28'sd1000
`define FILT_MAX_S    7'd100
`define MASTER_FULL   10'd1000
`define SLAVE_LO_DEF  16'sd0
`define SLAVE_HI_DEF  16'sd8000

// ----------------------------------------------------------------------
// sample tick timing
// ----------------------------------------------------------------------
`define CLK_MHZ          100
`define SAMPLE_PERIOD_US 100000
`define SAMPLE_CYCLES    (`SAMPLE_PERIOD_US * `CLK_MHZ)
`define TICKS_PER_SEC    (1000000 / `SAMPLE_PERIOD_US)

`endif

/* core/pv_cond_pkg.sv */
// types shared by the pv conditioning block
`include "pv_cond_defines.svh"

package pv_cond_pkg;

    // combine selector codes as held in the control word
    typedef enum logic [2:0] {
        COMBINE_MAX   = 3'h0,
        COMBINE_MIN   = 3'h1,
        COMBINE_AVG   = 3'h2,
        COMBINE_DIFF  = 3'h3,
        COMBINE_FIRST = 3'h4
    } combine_e;

    typedef logic signed [`PV_W-1:0] pv_t;

    // whole state of the top module
    typedef struct packed {
        combine_e           combineSelect;
        logic               overPolicy;
        logic               controlHold;
        logic               cascadeOn;
        logic               linear1;
        logic               linear2;
        logic signed [15:0] bias1;
        logic signed [15:0] bias2;
        logic [10:0]        slope1;
        logic [10:0]        slope2;
        logic [6:0]         filt1;
        logic [6:0]         filt2;
        logic signed [15:0] scaleLo;
        logic signed [15:0] scaleHi;
        logic [6:0]         svFilt;
        logic               selRejected;
        logic               scaleRejected;
        logic               rangeRejected;
        logic               wbAck;
        logic [31:0]        wbDat;
        logic [31:0]        tickCnt;
        logic [2:0]         tickPipe;
        pv_t                raw1;
        pv_t                raw2;
        pv_t                scaledSv;
        logic               over1;
        logic               over2;
        pv_t                pv;
        logic               pvOverRange;
        logic               pvValid;
        logic               finalIsSecond;
    } top_state_s;

endpackage : pv_cond_pkg

/* core/lag_filter.sv */
// first-order lag filter updated once per sample tick
`timescale 1ns/1ps
`default_nettype none

module lag_filter #(
    parameter int W             = 20,
    parameter int TICKS_PER_SEC = 10
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                srst,
    // update strobe and time constant in seconds, zero means off
    input  wire logic                tick,
    input  wire logic [6:0]          tcSec,
    // sample in, smoothed value out
    input  wire logic signed [W-1:0] x,
    output logic signed [W-1:0]      y
);
    typedef struct packed {
        logic signed [W+15:0] acc;
        logic                 primed;
    } lag_state_s;

    lag_state_s st;
    lag_state_s next_st;

    logic signed [W+23:0] diffScaled;
    logic signed [W+23:0] divisor;
    logic signed [W+23:0] step;

    // acc holds y with 16 fraction bits; step = (x - y) / (tc * ticks)
    always_comb begin
        next_st    = st;
        diffScaled = ($signed({{8{x[W-1]}}, x, 16'h0000}) - $signed({{8{st.acc[W+15]}}, st.acc}));
        divisor    = $signed((W+24)'(tcSec) * (W+24)'(TICKS_PER_SEC));
        step       = (divisor == '0) ? diffScaled : diffScaled / divisor;
        if (tick) begin
            // first sample or filter off: follow the input directly
            if (!st.primed || tcSec == 7'h00) begin
                next_st.acc = $signed({x, 16'h0000});
            end else begin
                next_st.acc = st.acc + step[W+15:0];
            end
            next_st.primed = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign y = st.acc[W+15:16];

endmodule : lag_filter

`default_nettype wire

/* core/dual_input_pv_conditioning.sv */
// two-input process value conditioning with internal cascade setpoint scaling
`timescale 1ns/1ps
`default_nettype none

`include "pv_cond_defines.svh"

module dual_input_pv_conditioning #(
    parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES,
    parameter int TICKS_PER_SEC = `TICKS_PER_SEC,
    parameter logic signed [15:0] SLAVE_RANGE_LO = `SLAVE_LO_DEF,
    parameter logic signed [15:0] SLAVE_RANGE_HI = `SLAVE_HI_DEF
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                srst,
    // wishbone slave
    input  wire logic                wbCyc,
    input  wire logic                wbStb,
    input  wire logic                wbWe,
    input  wire logic [7:0]          wbAdr,
    input  wire logic [3:0]          wbSel,
    input  wire logic [31:0]         wbDatI,
    output logic                     wbAck,
    output logic [31:0]              wbDatO,
    // measurement samples, already linearised or root-extracted upstream
    input  wire logic signed [15:0]  sample1,
    input  wire logic signed [15:0]  sample2,
    input  wire logic                overRange1,
    input  wire logic                overRange2,
    // master loop output in tenths of a percent
    input  wire logic [9:0]          masterOut,
    // conditioned results
    output pv_cond_pkg::pv_t         pv,
    output logic                     pvOverRange,
    output logic                     pvValid,
    output pv_cond_pkg::pv_t         slaveSv,
    output logic                     finalIsSecond
);
    import pv_cond_pkg::*;

    top_state_s st;
    top_state_s next_st;

    // filter outputs
    pv_t filt1Out;
    pv_t filt2Out;
    pv_t svFiltOut;

    // combinational helpers
    logic               busReq;
    logic               wr;
    logic [31:0]        rdMux;
    logic signed [15:0] wrHalf;
    logic               wrHalfOk;
    logic [10:0]        effSlope1;
    logic [10:0]        effSlope2;
    logic signed [27:0] prod1;
    logic signed [27:0] prod2;
    logic signed [27:0] q1;
    logic signed [27:0] q2;
    logic signed [31:0] span;
    logic signed [31:0] svMul;
    pv_t                maxV;
    pv_t                minV;
    logic signed [`PV_W:0] sumV;
    pv_t                combined;
    logic               overFlag;

    // ------------------------------------------------------------------
    // per-input lag filters and the slave setpoint filter
    // ------------------------------------------------------------------
    lag_filter #(.W(`PV_W), .TICKS_PER_SEC(TICKS_PER_SEC)) u_filt1 (
        .clk   (clk),
        .srst  (srst),
        .tick  (st.tickPipe[0]),
        .tcSec (st.filt1),
        .x     (st.raw1),
        .y     (filt1Out)
    );

    lag_filter #(.W(`PV_W), .TICKS_PER_SEC(TICKS_PER_SEC)) u_filt2 (
        .clk   (clk),
        .srst  (srst),
        .tick  (st.tickPipe[0]),
        .tcSec (st.filt2),
        .x     (st.raw2),
        .y     (filt2Out)
    );

    lag_filter #(.W(`PV_W), .TICKS_PER_SEC(TICKS_PER_SEC)) u_svfilt (
        .clk   (clk),
        .srst  (srst),
        .tick  (st.tickPipe[0]),
        .tcSec (st.svFilt),
        .x     (st.scaledSv),
        .y     (svFiltOut)
    );

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    always_comb begin
        rdMux = 32'h0000_0000;
        case (wbAdr)
            `REG_CTRL: begin
                rdMux[`CTRL_SEL_HI:`CTRL_SEL_LO] = st.combineSelect;
                rdMux[`CTRL_POLICY]  = st.overPolicy;
                rdMux[`CTRL_HOLD]    = st.controlHold;
                rdMux[`CTRL_CASCADE] = st.cascadeOn;
                rdMux[`CTRL_LINEAR1] = st.linear1;
                rdMux[`CTRL_LINEAR2] = st.linear2;
            end
            `REG_BIAS1:    rdMux = 32'($signed(st.bias1));
            `REG_BIAS2:    rdMux = 32'($signed(st.bias2));
            `REG_SLOPE1:   rdMux[10:0] = st.slope1;
            `REG_SLOPE2:   rdMux[10:0] = st.slope2;
            `REG_FILT1:    rdMux[6:0] = st.filt1;
            `REG_FILT2:    rdMux[6:0] = st.filt2;
            `REG_SCALE_LO: rdMux = 32'($signed(st.scaleLo));
            `REG_SCALE_HI: rdMux = 32'($signed(st.scaleHi));
            `REG_SV_FILT:  rdMux[6:0] = st.svFilt;
            `REG_STATUS: begin
                rdMux[`STAT_SEL_REJ]   = st.selRejected;
                rdMux[`STAT_SCALE_REJ] = st.scaleRejected;
                rdMux[`STAT_RANGE_REJ] = st.rangeRejected;
                rdMux[`STAT_OVER]      = st.pvOverRange;
                rdMux[`STAT_OVER1]     = st.over1;
                rdMux[`STAT_OVER2]     = st.over2;
            end
            `REG_PV:       rdMux = 32'($signed(st.pv));
            `REG_SLAVE_SV: rdMux = 32'($signed(svFiltOut));
            `REG_COND1:    rdMux = 32'($signed(filt1Out));
            `REG_COND2:    rdMux = 32'($signed(filt2Out));
            default:       rdMux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // arithmetic: slope, combine, setpoint scaling
    // ------------------------------------------------------------------
    always_comb begin
        // thermocouple and rtd inputs always run at unity slope
        effSlope1 = st.linear1 ? st.slope1 : `SLOPE_UNITY;
        effSlope2 = st.linear2 ? st.slope2 : `SLOPE_UNITY;
        // slope is in thousandths, applied to the upstream-processed sample
        prod1 = $signed({1'b0, effSlope1}) * sample1;
        prod2 = $signed({1'b0, effSlope2}) * sample2;
        q1    = prod1 / `SLOPE_SCALE;
        q2    = prod2 / `SLOPE_SCALE;
        maxV  = (filt1Out > filt2Out) ? filt1Out : filt2Out;
        minV  = (filt1Out < filt2Out) ? filt1Out : filt2Out;
        sumV  = {filt1Out[`PV_W-1], filt1Out} + {filt2Out[`PV_W-1], filt2Out};
        // floor + (ceiling - floor) * master / full scale
        span  = 32'($signed(st.scaleHi)) - 32'($signed(st.scaleLo));
        svMul = (span * $signed({22'h000000, masterOut})) / 32'sd1000;
    end

    // combine and over-range handling
    always_comb begin
        combined = filt1Out;
        overFlag = st.over1 | st.over2;
        case (st.combineSelect)
            COMBINE_MAX:   combined = maxV;
            COMBINE_MIN:   combined = minV;
            COMBINE_AVG:   combined = sumV[`PV_W:1];
            COMBINE_DIFF:  combined = filt1Out - filt2Out;
            COMBINE_FIRST: combined = filt1Out;
            default:       combined = filt1Out;
        endcase
        if (st.combineSelect == COMBINE_FIRST) begin
            overFlag = st.over1;
        end else if (st.combineSelect == COMBINE_DIFF) begin
            overFlag = st.over1 | st.over2;
        end else if (!st.overPolicy && (st.over1 ^ st.over2)) begin
            // one side healthy: carry on with it alone
            combined = st.over1 ? filt2Out : filt1Out;
            overFlag = 1'b0;
        end else begin
            overFlag = st.over1 | st.over2;
        end
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st  = st;
        busReq   = wbCyc & wbStb & ~st.wbAck;
        wr       = busReq & wbWe;
        wrHalf   = wbDatI[15:0];
        wrHalfOk = (wbDatI[31:16] == {16{wbDatI[15]}});

        // registered answer one cycle after the request, then dropped
        next_st.wbAck = busReq;
        next_st.wbDat = busReq ? rdMux : 32'h0000_0000;

        // sample tick divider and update pipeline
        next_st.tickPipe = {st.tickPipe[1:0], 1'b0};
        if (st.tickCnt == 32'(SAMPLE_CYCLES - 1)) begin
            next_st.tickCnt     = 32'h0000_0000;
            next_st.tickPipe[0] = 1'b1;
        end else begin
            next_st.tickCnt = st.tickCnt + 32'h0000_0001;
        end

        // tick stage 0: take samples, apply slope and bias, scale setpoint
        if (st.tickCnt == 32'(SAMPLE_CYCLES - 1)) begin
            next_st.raw1     = q1[`PV_W-1:0] + `PV_W'($signed(st.bias1));
            next_st.raw2     = q2[`PV_W-1:0] + `PV_W'($signed(st.bias2));
            next_st.over1    = overRange1;
            next_st.over2    = overRange2;
            next_st.scaledSv = `PV_W'($signed(st.scaleLo)) + svMul[`PV_W-1:0];
        end

        // tick stage 2: filters have settled, publish the process value
        next_st.pvValid = st.tickPipe[1];
        if (st.tickPipe[1]) begin
            next_st.pv          = combined;
            next_st.pvOverRange = overFlag;
        end
        next_st.finalIsSecond = st.cascadeOn;

        // register writes with range checks; refused writes keep the old value
        if (wr && wbSel == 4'hf) begin
            case (wbAdr)
                `REG_CTRL: begin
                    // selector moves only while control is already held
                    if (combine_e'(wbDatI[`CTRL_SEL_HI:`CTRL_SEL_LO]) != st.combineSelect) begin
                        if (st.controlHold && wbDatI[`CTRL_SEL_HI:`CTRL_SEL_LO] <= 3'h4) begin
                            next_st.combineSelect = combine_e'(wbDatI[2:0]);
                        end else begin
                            next_st.selRejected = 1'b1;
                        end
                    end
                    next_st.overPolicy  = wbDatI[`CTRL_POLICY];
                    next_st.controlHold = wbDatI[`CTRL_HOLD];
                    next_st.cascadeOn   = wbDatI[`CTRL_CASCADE];
                    next_st.linear1     = wbDatI[`CTRL_LINEAR1];
                    next_st.linear2     = wbDatI[`CTRL_LINEAR2];
                end
                `REG_BIAS1, `REG_BIAS2: begin
                    if (wrHalfOk && wrHalf >= `BIAS_MIN && wrHalf <= `BIAS_MAX) begin
                        if (wbAdr == `REG_BIAS1) begin
                            next_st.bias1 = wrHalf;
                        end else begin
                            next_st.bias2 = wrHalf;
                        end
                    end else begin
                        next_st.rangeRejected = 1'b1;
                    end
                end
                `REG_SLOPE1, `REG_SLOPE2: begin
                    if (wbDatI[31:11] == 21'h000000 && wbDatI[10:0] >= `SLOPE_MIN
                        && wbDatI[10:0] <= `SLOPE_MAX) begin
                        if (wbAdr == `REG_SLOPE1) begin
                            next_st.slope1 = wbDatI[10:0];
                        end else begin
                            next_st.slope2 = wbDatI[10:0];
                        end
                    end else begin
                        next_st.rangeRejected = 1'b1;
                    end
                end
                `REG_FILT1, `REG_FILT2, `REG_SV_FILT: begin
                    if (wbDatI[31:7] == 25'h0000000 && wbDatI[6:0] <= `FILT_MAX_S) begin
                        if (wbAdr == `REG_FILT1) begin
                            next_st.filt1 = wbDatI[6:0];
                        end else if (wbAdr == `REG_FILT2) begin
                            next_st.filt2 = wbDatI[6:0];
                        end else begin
                            next_st.svFilt = wbDatI[6:0];
                        end
                    end else begin
                        next_st.rangeRejected = 1'b1;
                    end
                end
                `REG_SCALE_LO: begin
                    if (!wrHalfOk || wrHalf < SLAVE_RANGE_LO || wrHalf > SLAVE_RANGE_HI) begin
                        next_st.rangeRejected = 1'b1;
                    end else if (wrHalf > st.scaleHi) begin
                        next_st.scaleRejected = 1'b1;
                    end else begin
                        next_st.scaleLo = wrHalf;
                    end
                end
                `REG_SCALE_HI: begin
                    if (!wrHalfOk || wrHalf < SLAVE_RANGE_LO || wrHalf > SLAVE_RANGE_HI) begin
                        next_st.rangeRejected = 1'b1;
                    end else if (wrHalf < st.scaleLo) begin
                        next_st.scaleRejected = 1'b1;
                    end else begin
                        next_st.scaleHi = wrHalf;
                    end
                end
                `REG_STATUS: begin
                    // write one to clear; a set in the same cycle cannot occur here
                    next_st.selRejected   = st.selRejected & ~wbDatI[`STAT_SEL_REJ];
                    next_st.scaleRejected = st.scaleRejected & ~wbDatI[`STAT_SCALE_REJ];
                    next_st.rangeRejected = st.rangeRejected & ~wbDatI[`STAT_RANGE_REJ];
                end
                default: begin
                    next_st.wbDat = 32'h0000_0000;
                end
            endcase
        end else if (wr) begin
            // partial-lane writes are not supported: flag them
            next_st.rangeRejected = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            st               <= '0;
            st.combineSelect <= COMBINE_DIFF;
            st.slope1        <= `SLOPE_UNITY;
            st.slope2        <= `SLOPE_UNITY;
            st.linear1       <= 1'b1;
            st.linear2       <= 1'b1;
            st.scaleLo       <= SLAVE_RANGE_LO;
            st.scaleHi       <= SLAVE_RANGE_HI;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from state flops
    assign wbAck         = st.wbAck;
    assign wbDatO        = st.wbDat;
    assign pv            = st.pv;
    assign pvOverRange   = st.pvOverRange;
    assign pvValid       = st.pvValid;
    assign slaveSv       = svFiltOut;
    assign finalIsSecond = st.finalIsSecond;

endmodule : dual_input_pv_conditioning

`default_nettype wire

/* verif/pv_cond_asserts.sv */
// port assertions for the pv conditioning block
`timescale 1ns/1ps
`default_nettype none
module pv_cond_asserts (
    // clock, reset, bus and results
    input wire logic             clk, srst, wbCyc, wbStb, wbAck, pvValid, pvOverRange,
    input wire logic [31:0]      wbDatO,
    input wire pv_cond_pkg::pv_t pv, slaveSv
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // a change of the setpoint output is followed by pvValid within two cycles
    sequence s_soon; ##[0:2] pvValid; endsequence
    property p_ack; wbCyc && wbStb && !wbAck |=> wbAck; endproperty
    property p_ackOne; wbAck |=> !wbAck; endproperty
    property p_ackCause; $rose(wbAck) |-> $past(wbCyc && wbStb); endproperty
    property p_datIdle; !wbAck |-> wbDatO == 32'h0; endproperty
    property p_gap; pvValid |=> !pvValid [*8]; endproperty
    property p_pvHold; !$stable(pv) |-> pvValid; endproperty
    property p_overHold; !$stable(pvOverRange) |-> pvValid; endproperty
    property p_svHold; !$stable(slaveSv) |-> s_soon; endproperty
    a_ack: assert property (p_ack) else $error("request not answered");
    a_ackOne: assert property (p_ackOne) else $error("ack too long");
    a_ackCause: assert property (p_ackCause) else $error("ack without request");
    a_datIdle: assert property (p_datIdle) else $error("read data outside ack");
    a_gap: assert property (p_gap) else $error("results too close");
    a_pvHold: assert property (p_pvHold) else $error("pv moved off tick");
    a_overHold: assert property (p_overHold) else $error("flag moved off tick");
    a_svHold: assert property (p_svHold) else $error("setpoint moved off tick");
endmodule : pv_cond_asserts
bind dual_input_pv_conditioning pv_cond_asserts chk (.clk(clk), .srst(srst), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbAck(wbAck), .pvValid(pvValid), .pvOverRange(pvOverRange),
    .wbDatO(wbDatO), .pv(pv), .slaveSv(slaveSv));
`default_nettype wire

/* verif/pv_source.sv */
// far side model: two digitised samples, their over-range levels and the master output
`timescale 1ns/1ps
`default_nettype none
module pv_source (
    // clock and requested values
    input  wire logic               clk,
    input  wire logic signed [15:0] want1, want2,
    input  wire logic               wantO1, wantO2,
    input  wire logic [9:0]         wantM,
    // values seen by the block
    output logic signed [15:0]      sample1 = 16'h0, sample2 = 16'h0,
    output logic                    over1 = 1'b0, over2 = 1'b0,
    output logic [9:0]              master = 10'h0
);
    // already linearised voltage samples, changed just after an edge
    always @(posedge clk) begin
        {sample1, sample2, over1, over2, master} <= {want1, want2, wantO1, wantO2, wantM};
    end
endmodule : pv_source
`default_nettype wire

/* verif/dual_input_pv_conditioning_bench.sv */
// self-checking bench for the pv conditioning block
`timescale 1ns/1ps
`default_nettype none
module dual_input_pv_conditioning_bench;
    import pv_cond_pkg::*;
    logic clk = 0, srst = 1, wbCyc = 0, wbStb = 0, wbWe = 0, o1 = 0, wbAck, r1, r2, ovr, vld;
    logic o2 = 0, f, fis;
    logic [7:0] wbAdr = 8'h0, ra[5] = '{8'h00, 8'h04, 8'h0c, 8'h14, 8'h20};
    logic [31:0] wbDatI = 32'h0, wbDatO, rv[5] = '{32'hc3, 32'h0, 32'h3e8, 32'h0, 32'h1f40};
    logic [3:0] wbSel = 4'h0;
    logic signed [15:0] w1 = 16'h0, w2 = 16'h0, s1, s2;
    logic [9:0] wm = 10'h0, mo;
    logic [41:0] pq[$], rq[$];
    pv_t pv, slaveSv;
    int nMismatch = 0, cmpCount = 0, a, b, m, c1, c2, e;
    always #5 clk = ~clk;
    pv_source src (.clk(clk), .want1(w1), .want2(w2), .wantO1(o1), .wantO2(o2),
        .wantM(wm), .sample1(s1), .sample2(s2), .over1(r1), .over2(r2), .master(mo));
    dual_input_pv_conditioning #(.SAMPLE_CYCLES(20), .TICKS_PER_SEC(1)) dut (.clk(clk),
        .srst(srst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
        .wbDatI(wbDatI), .wbAck(wbAck), .wbDatO(wbDatO), .sample1(s1), .sample2(s2),
        .overRange1(r1), .overRange2(r2), .masterOut(mo), .pv(pv), .pvOverRange(ovr),
        .pvValid(vld), .slaveSv(slaveSv), .finalIsSecond(fis));
    task check(input logic [41:0] seen, input logic [41:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            nMismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task end_of_test;
        if (nMismatch == 0 && cmpCount > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    // one classic cycle, held until ack is sampled
    task wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        @(posedge clk);
        {wbCyc, wbStb, wbWe, wbAdr, wbDatI, wbSel} <= {2'b11, we, adr, d, 4'hf};
        do @(posedge clk); while (wbAck !== 1'b1);
        {wbCyc, wbStb} <= 2'b00;
    endtask : wb
    task rd(input logic [7:0] adr, input logic [31:0] x);
        rq.push_back({10'h0, x});
        wb(1'b0, adr, 32'h0);
    endtask : rd
    // new inputs; one result is let pass so the noted one is built from them
    task pvchk(input int s, input logic [1:0] o, input int p);
        a = $urandom % 2000;
        b = $urandom % 2000;
        m = $urandom % 1001;
        {w1, w2, wm, o2, o1} <= {16'(a), 16'(b), 10'(m), o};
        c1 = a + 50;
        c2 = p == 1 ? b : b * 3 / 2;
        e = s == 0 ? (c1 > c2 ? c1 : c2) : s == 1 ? (c1 < c2 ? c1 : c2) : s == 2 ?
            (c1 + c2) >>> 1 : s == 3 ? c1 - c2 : c1;
        // one input over range under policy 0: the healthy one carries on
        if (p == 0 && s < 3 && o == 2'b01) e = c2;
        if (p == 0 && s < 3 && o == 2'b10) e = c1;
        f = s == 4 ? o[0] : (s == 3 || p == 1) ? |o : &o;
        @(negedge clk iff vld); @(negedge clk);
        pq.push_back({1'(p), 20'(m * 8), f, 20'(e)});
        // return on the checked edge so the next inputs change on a rising edge
        @(posedge clk iff vld === 1'b1);
    endtask : pvchk
    // watches results and read data against the oldest note
    always @(posedge clk) begin
        if (vld === 1'b1 && pq.size() > 0)
            check({fis, slaveSv, ovr, pv}, pq.pop_front());
        if (wbAck === 1'b1 && wbWe === 1'b0 && rq.size() > 0)
            check({10'h0, wbDatO}, rq.pop_front());
    end
    initial begin
        a = $urandom(79);
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        foreach (ra[i]) rd(ra[i], rv[i]);
        wb(1'b1, 8'h04, 32'd50); wb(1'b1, 8'h10, 32'd1500); wb(1'b1, 8'h28, 32'h3f);
        // out of range bias and floor, inverted scale, selector change while running
        wb(1'b1, 8'h04, 32'd10001); wb(1'b1, 8'h1c, 32'd9000); wb(1'b1, 8'h1c, 32'd5000);
        wb(1'b1, 8'h20, 32'd4000); wb(1'b1, 8'h00, 32'hc0);
        rd(8'h04, 32'd50); rd(8'h20, 32'h1f40); rd(8'h00, 32'hc3);
        rd(8'h28, 32'h7); rd(8'h1c, 32'd5000); wb(1'b1, 8'h1c, 32'h0);
        wb(1'b1, 8'h00, 32'hf3);
        for (int s = 0; s < 5; s++) for (int p = 0; p < 2; p++) begin
            // cascade follows policy; the second input runs at unity slope under policy 1
            wb(1'b1, 8'h00, 32'h50 | s | p << 3 | p << 5 | (1 - p) << 7);
            for (int o = 0; o < 4; o++) pvchk(s, 2'(o), p);
        end
        end_of_test();
    end
    initial begin
        repeat (40000) @(posedge clk);
        nMismatch++;
        end_of_test();
    end
endmodule : dual_input_pv_conditioning_bench
`default_nettype wire
